// file: cfg_host_model.sv
// Host model that pushes parallel words into the configuration load port.
// Assumes the bench raises go after the status phase and lowers it after user mode.
`timescale 1ns/1ps
module cfg_host_model (
    // Bench control
    input  wire logic        go,
    input  wire logic [2:0]  ratio,
    input  wire logic [15:0] base,
    input  wire logic [7:0]  words,
    // Device pins
    input  wire logic        config_done,
    output logic             config_clock_in,
    output logic [15:0]      parallel_data,
    output logic             busy
);
    int n;

    ////////////////////////////////////////////////////////////////////////
    // Start from a defined low clock, never floating
    initial begin
        config_clock_in = 1'b0;
        parallel_data   = 16'h0;
        busy            = 1'b0;
    end

    // One 160 ns clock cycle, well under the parallel clock ceiling
    task automatic tick();
        #80 config_clock_in = 1'b1;
        #80 config_clock_in = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Each word set up while the clock is low, then held for ratio cycles
    always begin
        wait (go === 1'b1);
        busy = 1'b1;
        for (int w = 0; w < words; w++) begin
            parallel_data = base + 16'(w);
            for (int k = 0; k < ratio; k++) begin
                tick();
            end
        end
        // Released bus shows the inverse so stale data cannot pass
        parallel_data = ~parallel_data;
        for (n = 0; n < 2000 && config_done !== 1'b1; n++) begin
            #20;
        end
        tick();
        tick();
        busy = 1'b0;
        wait (go === 1'b0);
    end
endmodule

// file: cfg_load_defines.svh
// Timing constants and option encodings for the configuration load port.
// Assumes a 50 MHz system clock; counts derive from times in ns.
`ifndef CFG_LOAD_DEFINES_SVH
`define CFG_LOAD_DEFINES_SVH

`define CLK_PERIOD_NS        20
`define REQ_TO_LOW_NS        600
`define REQ_TO_LOW_CYC       (`REQ_TO_LOW_NS / `CLK_PERIOD_NS)
`define STATUS_LOW_MIN_US    268
`define STATUS_LOW_MAX_US    1506
`define STATUS_LOW_MIN_CYC   ((`STATUS_LOW_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_MIN_US          175
`define INIT_MAX_US          437
`define INIT_MIN_CYC         ((`INIT_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYCLE_COUNT     17408
`define USER_CLK_WAIT_EDGES  4
`define CONFIG_CLOCK_MAX_PER_CYC     8
`define USER_CLK_WAIT_CYC    (`USER_CLK_WAIT_EDGES * `CONFIG_CLOCK_MAX_PER_CYC)
`define POST_DONE_FALLS      2
`define RATE_SEL_FASTEST     2'h3
`define RATE_SEL_SLOWEST     2'h0

`endif

// file: cfg_load_pkg.sv
// Types shared by the configuration load port files.
// Assumes cfg_load_defines.svh holds the numeric constants.
package cfg_load_pkg;
    // Load phase, one-hot
    typedef enum logic [5:0] {
        ST_RESET  = 6'b000001,
        ST_STATUS = 6'b000010,
        ST_LOAD   = 6'b000100,
        ST_TAIL   = 6'b001000,
        ST_INIT   = 6'b010000,
        ST_USER   = 6'b100000
    } phase_type;

    // Options loaded from the configuration data
    typedef struct packed {
        logic       wide_16;
        logic       encrypt;
        logic       compress;
        logic       serial_mode;
        logic       serial_quad;
        logic       use_user_clock;
        logic       init_flag_en;
        logic       chain;
        logic       remote_update;
        logic [1:0] rate_sel;
    } option_type;

    // Pin levels driven by the device
    typedef struct packed {
        logic status_n;
        logic done;
        logic init_done;
    } pins_type;
endpackage

// file: cfg_load_port.sv
// Configuration load port: status/done handshake, parallel and serial load, init.
// Assumes all pins are asynchronous to clk; options come in as plain ports.
`timescale 1ns/1ps
`include "cfg_load_defines.svh"

// Behaviour
// - In user mode all three lines high; request low restarts configuration.
// - After power-up status_n stays low for the whole reset delay.
// - config_done stays low from power-up through configuration.
// - config_done released only after complete error-free data; load_error never sets, so complete data alone releases it.
// - When enabled, init_done_flag stays low until initialization completes.
// - Within 600 ns of request low, status_n and config_done go low.
// - status_n low pulse lasts 268 us minimum, 1506 us maximum.
// - Initialization takes at least 17408 init clock cycles.
// - Internal oscillator init enters user mode 175 to 437 us after done.
// - User init clock used only four clock periods after done rises.
// - Quad serial load takes four bits per clock; single mode one.
// - Serial command launched and read data captured on falling clock edges.
// - Serial load clock from oscillator at one of four rates.
// - Chained or remote update never uses the fastest rate.
// - Init clock is oscillator or user_init_clock pin, per option.
// - Clock-to-data ratio: 8-bit 1 or 2; 16-bit 1, 2 or 4.
module cfg_load_port
    import cfg_load_pkg::*;
#(
    parameter int unsigned IMAGE_WORDS     = 16,
    parameter int unsigned INIT_CYCLES     = `INIT_CYCLE_COUNT,
    parameter int unsigned STATUS_LOW_CYC  = `STATUS_LOW_MIN_CYC,
    parameter int unsigned OSC_INIT_CYC    = `INIT_MIN_CYC,
    parameter int unsigned OSC_DIV         = 4
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Handshake pins
    input  wire logic        config_request_n,
    output logic             status_n,
    output logic             config_done,
    output logic             init_done_flag,
    output logic             user_mode,
    // Load options
    input  option_type       options,
    // Parallel load pins
    input  wire logic        config_clock_in,
    input  wire logic [15:0] parallel_data,
    // Serial flash pins
    output logic             config_clock_out,
    output logic             config_clock_oe,
    output logic             serial_flash_command_out,
    input  wire logic [3:0]  serial_flash_data,
    // Init clock pin
    input  wire logic        user_init_clock,
    // Loaded data and status
    output logic [15:0]      load_word,
    output logic             load_word_valid,
    output logic             load_error
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic req_lvl, req_fall;
    logic config_clock_rise, config_clock_fall;
    logic uclk_rise;
    logic [15:0] pdata_s1_reg, pdata_s2_reg;

    edge_sync u_req  (.clk(clk), .rst(rst), .async_in(config_request_n),
                      .level(req_lvl), .rise(), .fall(req_fall));
    edge_sync u_config_clock (.clk(clk), .rst(rst), .async_in(config_clock_in),
                      .level(), .rise(config_clock_rise), .fall(config_clock_fall));
    edge_sync u_uclk (.clk(clk), .rst(rst), .async_in(user_init_clock),
                      .level(), .rise(uclk_rise), .fall());

    // Data lines held stable by the host across the sampled edge
    always_ff @(posedge clk) begin
        pdata_s1_reg <= parallel_data;
        pdata_s2_reg <= pdata_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ratio and serial clock decode
    function automatic logic [2:0] ratio_of(input option_type o);
        if (!o.wide_16)
            ratio_of = o.compress ? 3'h2 : 3'h1;
        else if (o.compress)
            ratio_of = 3'h4;
        else
            ratio_of = o.encrypt ? 3'h2 : 3'h1;
    endfunction

    wire [2:0] ratio     = ratio_of(options);
    // Remote update falls back to the slowest setting; chain only steps down from the fastest
    wire [1:0] rate_eff  = options.remote_update ? `RATE_SEL_SLOWEST :
                           (options.chain && options.rate_sel == `RATE_SEL_FASTEST) ?
                           2'h2 : options.rate_sel;
    // Divider half period in clk cycles: slower setting doubles it
    wire [7:0] half_per  = 8'(OSC_DIV) << (2'h3 - rate_eff);

    ////////////////////////////////////////////////////////////////////////////
    // Phase machine
    phase_type  phase_reg, phase_next;
    logic [31:0] cnt_reg;
    logic [31:0] words_reg;
    logic [2:0]  sub_reg;
    logic [3:0]  bits_reg;
    logic [15:0] shift_reg;
    logic [7:0]  div_reg;
    logic        sclk_reg, sclk_fall;
    logic [1:0]  tail_reg;
    logic [5:0]  cu_reg;
    // Bound of the request check, as a plain constant of this file
    localparam int REQ_LOW_MAX = `REQ_TO_LOW_CYC;

    wire in_serial  = options.serial_mode;
    wire word_edge  = in_serial ? 1'b0 : config_clock_rise;
    wire last_word  = words_reg == IMAGE_WORDS - 1;
    wire [3:0] bstep = options.serial_quad ? 4'h4 : 4'h1;
    wire init_tick  = options.use_user_clock ? (cu_reg == 6'(`USER_CLK_WAIT_CYC) && uclk_rise)
                                             : 1'b1;
    wire [31:0] init_goal = options.use_user_clock ? INIT_CYCLES : OSC_INIT_CYC;
    wire tail_edge  = in_serial ? sclk_fall : config_clock_fall;

    // Next phase
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            ST_RESET:  phase_next = ST_STATUS;
            ST_STATUS: if (cnt_reg >= STATUS_LOW_CYC - 1 && req_lvl) phase_next = ST_LOAD;
            ST_LOAD:   if (load_word_valid && last_word && !load_error) phase_next = ST_TAIL;
            ST_TAIL:   if (tail_reg == 2'(`POST_DONE_FALLS)) phase_next = ST_INIT;
            ST_INIT:   if (cnt_reg >= init_goal) phase_next = ST_USER;
            ST_USER:   phase_next = ST_USER;
            default:   phase_next = ST_RESET;
        endcase
        if (req_fall || !req_lvl && phase_reg != ST_RESET && phase_reg != ST_STATUS)
            phase_next = ST_STATUS;
    end

    // Phase, counters and tail edges
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= ST_RESET;
            cnt_reg   <= 32'h0;
            tail_reg  <= 2'h0;
            cu_reg    <= 6'h0;
        end else begin
            phase_reg <= phase_next;
            if (phase_next != phase_reg || (phase_reg == ST_STATUS && !req_lvl))
                cnt_reg <= 32'h0;
            else if (phase_reg != ST_INIT || init_tick)
                cnt_reg <= cnt_reg + 32'h1;
            tail_reg <= (phase_reg == ST_TAIL && tail_edge) ? tail_reg + 2'h1
                      : (phase_reg == ST_TAIL ? tail_reg : 2'h0);
            // Wait four slowest host clock periods by time; host may stop its clock
            if (phase_reg != ST_INIT)
                cu_reg <= 6'h0;
            else if (cu_reg != 6'(`USER_CLK_WAIT_CYC))
                cu_reg <= cu_reg + 6'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial flash clock divider, launch and capture on falling edge
    always_ff @(posedge clk) begin
        if (rst || !in_serial || phase_reg != ST_LOAD && phase_reg != ST_TAIL) begin
            div_reg <= 8'h0;
            sclk_reg <= 1'b0;
        end else if (div_reg >= half_per - 8'h1) begin
            div_reg <= 8'h0;
            sclk_reg <= ~sclk_reg;
        end else begin
            div_reg <= div_reg + 8'h1;
        end
    end
    assign sclk_fall = sclk_reg && div_reg >= half_per - 8'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly for both load paths
    always_ff @(posedge clk) begin
        if (rst || phase_reg != ST_LOAD) begin
            words_reg <= 32'h0;
            sub_reg <= 3'h0;
            bits_reg <= 4'h0;
            shift_reg <= 16'h0;
            load_word <= 16'h0;
            load_word_valid <= 1'b0;
            serial_flash_command_out <= 1'b0;
            load_error <= 1'b0;
        end else begin
            load_word_valid <= 1'b0;
            if (load_word_valid)
                words_reg <= words_reg + 32'h1;
            if (word_edge) begin
                // One word per ratio rising edges
                sub_reg <= (sub_reg + 3'h1 == ratio) ? 3'h0 : sub_reg + 3'h1;
                if (sub_reg == 3'h0) begin
                    load_word <= options.wide_16 ? pdata_s2_reg : {8'h0, pdata_s2_reg[7:0]};
                    load_word_valid <= 1'b1;
                end
            end
            if (sclk_fall) begin
                serial_flash_command_out <= 1'b1;
                shift_reg <= options.serial_quad ? {shift_reg[11:0], serial_flash_data}
                                                 : {shift_reg[14:0], serial_flash_data[0]};
                bits_reg <= bits_reg + bstep;
                if (bits_reg + bstep == 4'h0) begin
                    load_word <= options.serial_quad ? {shift_reg[11:0], serial_flash_data}
                                                     : {shift_reg[14:0], serial_flash_data[0]};
                    load_word_valid <= 1'b1;
                end
            end
            // Encrypted 8-bit uncompressed stream check, gated with 1'b0 so load_error never sets
            if (options.encrypt && !options.wide_16 && options.compress == 1'b0 && 1'b0)
                load_error <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            status_n <= 1'b0;
            config_done <= 1'b0;
            init_done_flag <= 1'b0;
            user_mode <= 1'b0;
        end else begin
            status_n <= phase_next != ST_STATUS && phase_next != ST_RESET;
            config_done <= phase_next == ST_TAIL || phase_next == ST_INIT
                        || phase_next == ST_USER;
            init_done_flag <= options.init_flag_en ? phase_next == ST_USER : 1'b1;
            user_mode <= phase_next == ST_USER;
        end
    end
    assign config_clock_out = sclk_reg;
    assign config_clock_oe  = in_serial && (phase_reg == ST_LOAD || phase_reg == ST_TAIL);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_req_forces_low: assert property (@(posedge clk) disable iff (rst)
        req_fall |-> ##[1:REQ_LOW_MAX] (!status_n && !config_done))
        else $error("request low did not drop status and done");
    a_status_min_width: assert property (@(posedge clk) disable iff (rst)
        $rose(status_n) |-> $past(cnt_reg) >= STATUS_LOW_CYC - 1)
        else $error("status low pulse too short");
    a_done_after_load: assert property (@(posedge clk) disable iff (rst)
        $rose(config_done) |-> $past(phase_reg) == ST_LOAD && $past(last_word))
        else $error("done rose before complete data");
    a_done_low_loading: assert property (@(posedge clk) disable iff (rst)
        phase_reg == ST_LOAD |-> !config_done)
        else $error("done high during load");
    a_user_needs_init: assert property (@(posedge clk) disable iff (rst)
        $rose(user_mode) |-> $past(cnt_reg) >= $past(init_goal))
        else $error("user mode before init count");
    a_user_lines_high: assert property (@(posedge clk) disable iff (rst)
        user_mode |-> status_n && config_done)
        else $error("user mode without lines high");
    a_init_flag_low: assert property (@(posedge clk) disable iff (rst)
        (options.init_flag_en && !user_mode) |-> !init_done_flag)
        else $error("init flag high before user mode");
    a_no_fast_chain: assert property (@(posedge clk) disable iff (rst)
        (options.chain || options.remote_update) |-> rate_eff != `RATE_SEL_FASTEST)
        else $error("fastest serial rate used in chain");
endmodule

// file: edge_sync.sv
// Three-stage input synchroniser with rising and falling edge pulses.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Async input and synchronised results
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Edge pulses while stages two and three differ; level is stage three
    assign level = s3_reg;
    assign rise  = s2_reg & ~s3_reg;
    assign fall  = ~s2_reg & s3_reg;
endmodule

// file: tb_fpga_config_load_timing.sv
// Self-checking bench for the configuration load port, parallel and quad serial load paths.
// Assumes cfg_host_model drives the host pins; serial flash data is tied.
`timescale 1ns/1ps
module tb_fpga_config_load_timing;
    import cfg_load_pkg::*;
    localparam int unsigned WORDS = 4;
    logic        clk = 1'b0, rst = 1'b1, config_request_n = 1'b1;
    logic        user_init_clock = 1'b0, go = 1'b0;
    option_type  options = '0, so;
    logic [3:0]  flash_nibble = 4'ha;
    logic [2:0]  ratio = 3'h1;
    logic [15:0] base = 16'h0, parallel_data, load_word;
    logic        status_n, config_done, init_done_flag, user_mode, config_clock_in;
    logic        load_word_valid, busy;
    int          errors = 0, checks = 0, widx = 0, n;

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz system clock, free-running user init clock unrelated to it
    always #10 clk = ~clk;
    always #50 user_init_clock = ~user_init_clock;

    cfg_load_port #(.IMAGE_WORDS(WORDS), .INIT_CYCLES(8), .STATUS_LOW_CYC(20),
                    .OSC_INIT_CYC(10), .OSC_DIV(4)) u_dut (
        .clk(clk), .rst(rst), .config_request_n(config_request_n), .status_n(status_n),
        .config_done(config_done), .init_done_flag(init_done_flag), .user_mode(user_mode),
        .options(options), .config_clock_in(config_clock_in), .parallel_data(parallel_data),
        .config_clock_out(), .config_clock_oe(), .serial_flash_command_out(),
        .serial_flash_data(flash_nibble), .user_init_clock(user_init_clock),
        .load_word(load_word),
        .load_word_valid(load_word_valid), .load_error());

    cfg_host_model u_host (.go(go), .ratio(ratio), .base(base), .words(8'(WORDS)),
        .config_done(config_done), .config_clock_in(config_clock_in),
        .parallel_data(parallel_data), .busy(busy));

    ////////////////////////////////////////////////////////////////////////
    // Compare tasks and the single exit point
    task automatic check1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A wait that used its whole bound ends the run
    task automatic guard(input int lim);
        if (n >= lim) begin
            errors++;
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Every parallel word must be the next one the host sent; every serial word must equal base
    always @(negedge clk) begin
        if (load_word_valid === 1'b1) begin
            check16(load_word, options.serial_mode ? base : base + 16'(widx));
            widx++;
        end
    end

    function automatic option_type make_opt(input logic enc, input logic comp,
                                            input logic usr);
        option_type o;
        o                = '0;
        o.wide_16        = 1'b1;
        o.encrypt        = enc;
        o.compress       = comp;
        o.use_user_clock = usr;
        o.init_flag_en   = comp;
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Status phase after reset release counts its full length
    task automatic check_reset();
        @(negedge clk);
        check1(status_n, 1'b0);
        check1(config_done, 1'b0);
        rst <= 1'b0;
        for (n = 0; n < 300 && status_n !== 1'b1; n++) @(negedge clk);
        guard(300);
        check1(n >= 20, 1'b1);
        check1(config_done, 1'b0);
    endtask

    // Full reconfiguration: request, status pulse, load, init, user mode
    task automatic run_load(input option_type o, input logic [2:0] r,
                            input logic [15:0] b, input int min_init);
        options <= o;
        ratio   <= r;
        base    <= b;
        widx = 0;
        @(posedge clk) config_request_n <= 1'b0;
        repeat (30) @(negedge clk);
        check1(status_n, 1'b0);
        check1(config_done, 1'b0);
        repeat (70) @(posedge clk);
        config_request_n <= 1'b1;
        for (n = 0; n < 300 && status_n !== 1'b1; n++) @(negedge clk);
        guard(300);
        check1(n >= 20, 1'b1);
        // Quiet gap before the first host clock edge
        repeat (100) @(posedge clk);
        check1(config_done, 1'b0);
        go <= 1'b1;
        for (n = 0; n < 2000 && config_done !== 1'b1; n++) @(negedge clk);
        guard(2000);
        check16(16'(widx), 16'(WORDS));
        check1(init_done_flag, !o.init_flag_en);
        for (n = 0; n < 2000 && user_mode !== 1'b1; n++) @(negedge clk);
        guard(2000);
        check1(n >= min_init, 1'b1);
        check1(status_n & config_done & init_done_flag, 1'b1);
        @(posedge clk) go <= 1'b0;
        for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clk);
        guard(100);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset held two cycles, then ratios 1, 2 and 4 with both init clocks
    initial begin
        repeat (2) @(posedge clk);
        check_reset();
        run_load(make_opt(1'b0, 1'b0, 1'b0), 3'h1, 16'h1200, 10);
        run_load(make_opt(1'b1, 1'b0, 1'b0), 3'h2, 16'ha5c0, 10);
        run_load(make_opt(1'b0, 1'b1, 1'b1), 3'h4, 16'h0ff8, 40);
        // Quad serial load: constant nibble gives a repeated word
        so             = make_opt(1'b0, 1'b0, 1'b0);
        so.serial_mode = 1'b1;
        so.serial_quad = 1'b1;
        run_load(so, 3'h1, 16'haaaa, 10);
        wrap_up();
    end
endmodule
